// ---- rtl/smbus_slice_pkg.sv ----
package smbus_slice_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] RANGE_IDX   = 8'h07;
  localparam logic [7:0] SMB_IDX     = 8'h08;
  localparam logic [7:0] SECOND_IDX  = 8'h09;
  localparam logic [7:0] SLT_HI_IDX  = 8'h0A;
  localparam logic [7:0] SLT_LO_IDX  = 8'h0B;
  localparam logic [7:0] PRIMARY_IDX = 8'h10;
  localparam logic [7:0] CTRL_IDX    = 8'h11;
  localparam logic [7:0] STATE_IDX   = 8'h12;

  localparam logic [7:0] RANGE_ADDR   = {RANGE_IDX[5:0], 2'h0};
  localparam logic [7:0] SMB_ADDR     = {SMB_IDX[5:0], 2'h0};
  localparam logic [7:0] SECOND_ADDR  = {SECOND_IDX[5:0], 2'h0};
  localparam logic [7:0] SLT_HI_ADDR  = {SLT_HI_IDX[5:0], 2'h0};
  localparam logic [7:0] SLT_LO_ADDR  = {SLT_LO_IDX[5:0], 2'h0};
  localparam logic [7:0] PRIMARY_ADDR = {PRIMARY_IDX[5:0], 2'h0};
  localparam logic [7:0] CTRL_ADDR    = {CTRL_IDX[5:0], 2'h0};
  localparam logic [7:0] STATE_ADDR   = {STATE_IDX[5:0], 2'h0};

  // ----------------------------------------------------------------
  // Field positions of the SMBus control and status register
  // ----------------------------------------------------------------
  localparam int SMB_FAST_ACK      = 7;
  localparam int SMB_ALERT         = 6;
  localparam int SMB_SECOND        = 5;
  localparam int SMB_TICK_SEL      = 4;
  localparam int SMB_LOW_FLAG      = 3;
  localparam int SMB_FREE_FLAG     = 2;
  localparam int SMB_HIGH_LOW_FLAG = 1;
  localparam int SMB_IE            = 0;

  // Own control register fields
  localparam int CTRL_RANGE_EN = 0;
  localparam int CTRL_ACK_BIT  = 1;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [6:0] ALERT_ADDRESS = 7'h0C;
  localparam int         PRESCALE_DIV  = 64;
  localparam int         HIGH_DIV      = 512;
  localparam int         HIGH_SHIFT    = $clog2(HIGH_DIV);
  localparam int         TIMEOUT_W     = 16;

endpackage

// ---- rtl/interval_counter.sv ----
`timescale 1ns/10ps
// Counts ticks while a condition holds; restarts whenever it drops.
module interval_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         active,
  output logic      [W-1:0] count
);

  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (!active) begin
      next_count = '0;
    end else if (tick && (count != {W{1'b1}})) begin
      // Saturate so a stuck line never wraps back under the limit
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ---- rtl/address_matcher.sv ----
`timescale 1ns/10ps
module address_matcher (
  input  wire logic       [6:0] rx_address,
  input  wire logic       [6:0] primary_own_address,
  input  wire logic       [6:0] range_addr_field,
  input  wire logic             range_enabled,
  input  wire logic             range_match_enable,
  input  wire logic       [6:0] second_own_address,
  input  wire logic             second_address_enable,
  input  wire logic             alert_response_match_enable,
  output logic                  match
);

  always_comb begin
    match = (rx_address == primary_own_address);
    if (range_enabled && (rx_address == range_addr_field)) begin
      match = 1'b1;
    end
    if (range_enabled && range_match_enable && (rx_address > primary_own_address)
        && (rx_address <= range_addr_field)) begin
      match = 1'b1;
    end
    if (second_address_enable && (rx_address == second_own_address)) begin
      match = 1'b1;
    end
    if (alert_response_match_enable && (rx_address == smbus_slice_pkg::ALERT_ADDRESS)) begin
      match = 1'b1;
    end
  end

endmodule

// ---- rtl/smbus_slice.sv ----
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module smbus_slice #(
  parameter int PRESCALE = smbus_slice_pkg::PRESCALE_DIV
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [6:0]  rx_address,
  input  wire logic        rx_address_valid,
  input  wire logic        byte_received,
  output logic             address_match,
  output logic             ack_strobe,
  output logic             ack_nack,
  output logic             bus_free,
  output logic             timeout_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [6:0]  range_addr_field;
  logic [7:0]  smb;
  logic [6:0]  second_own_address;
  logic [7:0]  low_timeout_high_byte;
  logic [7:0]  low_timeout_low_byte;
  logic [6:0]  primary_own_address;
  logic [1:0]  ctrl;
  logic        awaiting_ack;
  logic [6:0]  next_range_addr_field;
  logic [7:0]  next_smb;
  logic [6:0]  next_second_own_address;
  logic [7:0]  next_low_timeout_high_byte;
  logic [7:0]  next_low_timeout_low_byte;
  logic [6:0]  next_primary_own_address;
  logic [1:0]  next_ctrl;
  logic        next_awaiting_ack;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_ack_strobe;
  logic        next_ack_nack;
  logic        next_address_match;

  logic        setup;
  logic        wr;
  logic        mapped;
  logic [15:0] low_timeout_value;
  logic [15:0] high_limit;
  logic [15:0] low_count;
  logic [15:0] both_high_count;
  logic [15:0] high_low_count;
  logic        tick;
  logic        low_set;
  logic        high_low_set;
  logic        range_enabled;
  logic        match;
  logic [5:0]  prescale;
  logic [5:0]  next_prescale;

  assign setup             = psel && !penable;
  assign wr                = psel && penable && pwrite;
  assign pready            = psel && penable;
  assign low_timeout_value = {low_timeout_high_byte, low_timeout_low_byte};
  assign high_limit        = low_timeout_value >> smbus_slice_pkg::HIGH_SHIFT;
  assign range_enabled     = (range_addr_field != 7'h00);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == smbus_slice_pkg::RANGE_ADDR) || (a == smbus_slice_pkg::SMB_ADDR)
             || (a == smbus_slice_pkg::SECOND_ADDR) || (a == smbus_slice_pkg::SLT_HI_ADDR)
             || (a == smbus_slice_pkg::SLT_LO_ADDR) || (a == smbus_slice_pkg::PRIMARY_ADDR)
             || (a == smbus_slice_pkg::CTRL_ADDR) || (a == smbus_slice_pkg::STATE_ADDR);
  endfunction

  assign mapped = is_mapped(paddr);

  // ----------------------------------------------------------------
  // Timeout clock and counters
  // ----------------------------------------------------------------
  always_comb begin
    next_prescale = prescale + 6'h01;
    if (prescale == 6'(PRESCALE - 1)) begin
      next_prescale = 6'h00;
    end
  end

  assign tick = smb[smbus_slice_pkg::SMB_TICK_SEL] || (prescale == 6'(PRESCALE - 1));

  interval_counter #(.W(smbus_slice_pkg::TIMEOUT_W)) low_ctr (
    .clk    (clk),
    .rstn   (rstn),
    .tick   (tick),
    .active (!scl_in),
    .count  (low_count)
  );

  // Disjoint conditions: any change of line levels restarts the count
  interval_counter #(.W(smbus_slice_pkg::TIMEOUT_W)) both_high_ctr (
    .clk    (clk),
    .rstn   (rstn),
    .tick   (tick),
    .active (scl_in && sda_in),
    .count  (both_high_count)
  );

  interval_counter #(.W(smbus_slice_pkg::TIMEOUT_W)) high_low_ctr (
    .clk    (clk),
    .rstn   (rstn),
    .tick   (tick),
    .active (scl_in && !sda_in),
    .count  (high_low_count)
  );

  assign low_set   = !scl_in && (low_timeout_value != 16'h0000)
                  && (low_count == low_timeout_value);
  assign high_low_set = scl_in && !sda_in && (high_low_count > high_limit);

  // Free while measuring and after the threshold alike
  assign bus_free    = scl_in && sda_in;
  assign timeout_irq = smb[smbus_slice_pkg::SMB_HIGH_LOW_FLAG] && smb[smbus_slice_pkg::SMB_IE];

  address_matcher matcher (
    .rx_address                  (rx_address),
    .primary_own_address         (primary_own_address),
    .range_addr_field            (range_addr_field),
    .range_enabled               (range_enabled),
    .range_match_enable          (ctrl[smbus_slice_pkg::CTRL_RANGE_EN]),
    .second_own_address          (second_own_address),
    .second_address_enable       (smb[smbus_slice_pkg::SMB_SECOND]),
    .alert_response_match_enable (smb[smbus_slice_pkg::SMB_ALERT]),
    .match                       (match)
  );

  // ----------------------------------------------------------------
  // Register writes, flags and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    next_range_addr_field      = range_addr_field;
    next_smb                   = smb;
    next_second_own_address    = second_own_address;
    next_low_timeout_high_byte = low_timeout_high_byte;
    next_low_timeout_low_byte  = low_timeout_low_byte;
    next_primary_own_address   = primary_own_address;
    next_ctrl                  = ctrl;
    next_awaiting_ack          = awaiting_ack;
    next_ack_strobe            = 1'b0;
    next_ack_nack              = ack_nack;
    next_address_match         = address_match;
    if (rx_address_valid) begin
      next_address_match = match;
    end
    if (wr) begin
      case (paddr)
        smbus_slice_pkg::RANGE_ADDR:   next_range_addr_field = pwdata[7:1];
        smbus_slice_pkg::SECOND_ADDR:  next_second_own_address = pwdata[7:1];
        smbus_slice_pkg::SLT_HI_ADDR:  next_low_timeout_high_byte = pwdata[7:0];
        smbus_slice_pkg::SLT_LO_ADDR:  next_low_timeout_low_byte = pwdata[7:0];
        smbus_slice_pkg::PRIMARY_ADDR: next_primary_own_address = pwdata[7:1];
        smbus_slice_pkg::CTRL_ADDR:    next_ctrl = pwdata[1:0];
        smbus_slice_pkg::SMB_ADDR: begin
          next_smb[7:4]                     = pwdata[7:4];
          next_smb[smbus_slice_pkg::SMB_IE] = pwdata[smbus_slice_pkg::SMB_IE];
          if (pwdata[smbus_slice_pkg::SMB_LOW_FLAG]) begin
            next_smb[smbus_slice_pkg::SMB_LOW_FLAG] = 1'b0;
          end
          if (pwdata[smbus_slice_pkg::SMB_HIGH_LOW_FLAG]) begin
            next_smb[smbus_slice_pkg::SMB_HIGH_LOW_FLAG] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Sets after clears so a same-cycle event is never lost
    if (low_set) begin
      next_smb[smbus_slice_pkg::SMB_LOW_FLAG] = 1'b1;
    end
    if (high_low_set) begin
      next_smb[smbus_slice_pkg::SMB_HIGH_LOW_FLAG] = 1'b1;
    end
    // Read-only, follows the lines and drops by itself
    next_smb[smbus_slice_pkg::SMB_FREE_FLAG] = scl_in && sda_in && (both_high_count > high_limit);
    if (byte_received) begin
      if (smb[smbus_slice_pkg::SMB_FAST_ACK]) begin
        next_awaiting_ack = 1'b1;
      end else begin
        next_ack_strobe = 1'b1;
        next_ack_nack   = ctrl[smbus_slice_pkg::CTRL_ACK_BIT];
      end
    end else if (wr && (paddr == smbus_slice_pkg::CTRL_ADDR) && awaiting_ack
                 && smb[smbus_slice_pkg::SMB_FAST_ACK]) begin
      next_awaiting_ack = 1'b0;
      next_ack_strobe   = 1'b1;
      next_ack_nack     = pwdata[smbus_slice_pkg::CTRL_ACK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // APB read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_pslverr = !mapped;
      next_prdata  = 32'h0000_0000;
      case (paddr)
        smbus_slice_pkg::RANGE_ADDR:   next_prdata[7:0] = {range_addr_field, 1'b0};
        smbus_slice_pkg::SMB_ADDR:     next_prdata[7:0] = smb;
        smbus_slice_pkg::SECOND_ADDR:  next_prdata[7:0] = {second_own_address, 1'b0};
        smbus_slice_pkg::SLT_HI_ADDR:  next_prdata[7:0] = low_timeout_high_byte;
        smbus_slice_pkg::SLT_LO_ADDR:  next_prdata[7:0] = low_timeout_low_byte;
        smbus_slice_pkg::PRIMARY_ADDR: next_prdata[7:0] = {primary_own_address, 1'b0};
        smbus_slice_pkg::CTRL_ADDR:    next_prdata[1:0] = ctrl;
        smbus_slice_pkg::STATE_ADDR:   next_prdata[3:0] = {awaiting_ack, address_match, timeout_irq, bus_free};
        default:                       next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      range_addr_field      <= 7'h00;
      smb                   <= smbus_slice_pkg::REG_RESET;
      second_own_address    <= 7'h00;
      low_timeout_high_byte <= smbus_slice_pkg::REG_RESET;
      low_timeout_low_byte  <= smbus_slice_pkg::REG_RESET;
      primary_own_address   <= 7'h00;
      ctrl                  <= 2'h0;
      awaiting_ack          <= 1'b0;
      prescale              <= 6'h00;
      prdata                <= 32'h0000_0000;
      pslverr               <= 1'b0;
      ack_strobe            <= 1'b0;
      ack_nack              <= 1'b0;
      address_match         <= 1'b0;
    end else begin
      range_addr_field      <= next_range_addr_field;
      smb                   <= next_smb;
      second_own_address    <= next_second_own_address;
      low_timeout_high_byte <= next_low_timeout_high_byte;
      low_timeout_low_byte  <= next_low_timeout_low_byte;
      primary_own_address   <= next_primary_own_address;
      ctrl                  <= next_ctrl;
      awaiting_ack          <= next_awaiting_ack;
      prescale              <= next_prescale;
      prdata                <= next_prdata;
      pslverr               <= next_pslverr;
      ack_strobe            <= next_ack_strobe;
      ack_nack              <= next_ack_nack;
      address_match         <= next_address_match;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  range_bit_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (setup && !pwrite && paddr == smbus_slice_pkg::RANGE_ADDR) |=> (prdata[0] == 1'b0))
    else $error("range register bit 0 read nonzero");

  range_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == smbus_slice_pkg::RANGE_ADDR) |=> (range_addr_field == $past(pwdata[7:1])))
    else $error("range address not stored from bits 7 to 1");

  irq_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    !smb[smbus_slice_pkg::SMB_IE] |-> !timeout_irq)
    else $error("timeout interrupt raised while disabled");

  low_disabled_a: assert property (@(posedge clk) disable iff (!rstn)
    (low_timeout_value == 16'h0000 && !smb[smbus_slice_pkg::SMB_LOW_FLAG])
    |=> !smb[smbus_slice_pkg::SMB_LOW_FLAG])
    else $error("low timeout flag set with zero value");

  high_flag_drop_a: assert property (@(posedge clk) disable iff (!rstn)
    !(scl_in && sda_in) |=> !smb[smbus_slice_pkg::SMB_FREE_FLAG])
    else $error("bus free flag stayed after lines changed");

  high_low_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == smbus_slice_pkg::SMB_ADDR && pwdata[smbus_slice_pkg::SMB_HIGH_LOW_FLAG] && !high_low_set)
    |=> !smb[smbus_slice_pkg::SMB_HIGH_LOW_FLAG])
    else $error("clock high data low flag not cleared by write one");

  bus_free_a: assert property (@(posedge clk) disable iff (!rstn)
    (scl_in && sda_in) |-> bus_free)
    else $error("bus not free while both lines high");

  fast_ack_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == smbus_slice_pkg::CTRL_ADDR && awaiting_ack && smb[smbus_slice_pkg::SMB_FAST_ACK]
     && !byte_received) |=> (ack_strobe && ack_nack == $past(pwdata[smbus_slice_pkg::CTRL_ACK_BIT])))
    else $error("fast acknowledge not produced from write");

  range_match_a: assert property (@(posedge clk) disable iff (!rstn)
    (rx_address_valid && range_enabled && ctrl[smbus_slice_pkg::CTRL_RANGE_EN]
     && rx_address > primary_own_address && rx_address <= range_addr_field) |=> address_match)
    else $error("address inside range not matched");

  alert_off_a: assert property (@(posedge clk) disable iff (!rstn)
    (rx_address_valid && rx_address == smbus_slice_pkg::ALERT_ADDRESS && !smb[smbus_slice_pkg::SMB_ALERT]
     && !range_enabled && !smb[smbus_slice_pkg::SMB_SECOND] && rx_address != primary_own_address)
    |=> !address_match)
    else $error("alert address matched while disabled");

endmodule

// ---- verification/bus_partner.sv ----
`timescale 1ns/10ps
// ----------------------------------------------
// Far side: other bus agents and the byte layer
// ----------------------------------------------
module bus_partner (
  input  wire logic       clk,
  output logic            scl,
  output logic            sda,
  output logic      [6:0] rx_address,
  output logic            rx_address_valid,
  output logic            byte_received
);
  // Pull-ups keep both lines high while nobody drives them
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    rx_address = 7'h55;
    rx_address_valid = 1'b0;
    byte_received = 1'b0;
  end

  task automatic lines(input logic c, input logic d, input int n);
    scl <= c;
    sda <= d;
    repeat (n) @(posedge clk);
  endtask

  task automatic send_addr(input logic [6:0] a);
    rx_address <= a;
    rx_address_valid <= 1'b1;
    @(posedge clk);
    rx_address_valid <= 1'b0;
    // Inverted once stale, so a design that reads it late cannot get lucky
    rx_address <= ~a;
    @(posedge clk);
  endtask

  task automatic send_byte();
    byte_received <= 1'b1;
    @(posedge clk);
    byte_received <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        clk, rstn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, scl_in, sda_in, rx_address_valid, byte_received;
  logic [6:0]  rx_address, pa, ra, sa;
  logic        address_match, ack_strobe, ack_nack, bus_free, timeout_irq;
  logic        vd, lastm;
  logic [32:0] rq[$];
  logic        mq[$];
  logic        aq[$];
  int          miscompares, checked;

  smbus_slice #(.PRESCALE(smbus_slice_pkg::PRESCALE_DIV)) i_smbus_slice (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .sda_in(sda_in), .rx_address(rx_address), .rx_address_valid(rx_address_valid),
    .byte_received(byte_received), .address_match(address_match), .ack_strobe(ack_strobe),
    .ack_nack(ack_nack), .bus_free(bus_free), .timeout_irq(timeout_irq));

  bus_partner partner (.clk(clk), .scl(scl_in), .sda(sda_in), .rx_address(rx_address),
    .rx_address_valid(rx_address_valid), .byte_received(byte_received));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------
  // APB master; expectation is queued for the monitor
  // ----------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e);
    logic [31:0] r;
    r = $urandom();
    rq.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[31:8], d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Waits as long as the slave asks; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask

  task automatic m(input logic [6:0] a, input logic e);
    mq.push_back(e);
    lastm = e;
    partner.send_addr(a);
  endtask

  // ----------------------------------------------
  // Output monitor: oldest note against what appears
  // ----------------------------------------------
  always @(posedge clk) begin
    vd <= rx_address_valid;
    if (rstn === 1'b1) begin
      if (psel && penable && pready) begin
        if (pwrite) chk({32'h0, pslverr}, {32'h0, rq[0][32]});
        else chk({pslverr, prdata}, rq[0]);
        void'(rq.pop_front());
      end
      if (vd === 1'b1) chk({32'h0, address_match}, {32'h0, mq.pop_front()});
      if (ack_strobe === 1'b1) begin
        // A strobe nobody asked for is itself a fault
        if (aq.size() == 0) chk(33'h1, 33'h0);
        else chk({32'h0, ack_nack}, {32'h0, aq.pop_front()});
      end
    end
  end

  initial begin
    #(25 * 20000);
    miscompares++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vd = 1'b0;
    lastm = 1'b0;
    miscompares = 0;
    checked = 0;
    void'($urandom(32'h964F0325));
    pa = 7'h20 + 7'($urandom_range(31, 0));
    ra = pa + 7'd5 + 7'($urandom_range(9, 0));
    sa = 7'h60 + 7'($urandom_range(15, 0));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(smbus_slice_pkg::RANGE_ADDR, 8'h00);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h00);
    apb(1'b1, 8'h00, 8'hFF, {1'b1, 32'h0});
    apb(1'b0, 8'h00, 8'h00, {1'b1, 32'h0});
    wr(smbus_slice_pkg::RANGE_ADDR, {ra, 1'b1});
    rd(smbus_slice_pkg::RANGE_ADDR, {ra, 1'b0});
    wr(smbus_slice_pkg::PRIMARY_ADDR, {pa, 1'b0});
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h00);
    m(pa + 7'd1, 1'b0);
    m(ra, 1'b1);
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h01);
    m(pa + 7'd2, 1'b1);
    m(ra, 1'b1);
    m(ra + 7'd1, 1'b0);
    wr(smbus_slice_pkg::RANGE_ADDR, 8'h00);
    m(pa + 7'd1, 1'b0);
    wr(smbus_slice_pkg::SECOND_ADDR, {sa, 1'b0});
    m(smbus_slice_pkg::ALERT_ADDRESS, 1'b0);
    m(sa, 1'b0);
    wr(smbus_slice_pkg::SMB_ADDR, 8'h60);
    m(smbus_slice_pkg::ALERT_ADDRESS, 1'b1);
    m(sa, 1'b1);
    wr(smbus_slice_pkg::SMB_ADDR, 8'h00);
    m(sa, 1'b0);
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h02);
    aq.push_back(1'b1);
    partner.send_byte();
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h00);
    aq.push_back(1'b0);
    partner.send_byte();
    wr(smbus_slice_pkg::SMB_ADDR, 8'h80);
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h02);
    partner.send_byte();
    aq.push_back(1'b1);
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h02);
    partner.send_byte();
    aq.push_back(1'b0);
    wr(smbus_slice_pkg::CTRL_ADDR, 8'h00);
    // Timeouts on the direct module clock first
    wr(smbus_slice_pkg::SMB_ADDR, 8'h10);
    partner.lines(1'b0, 1'b1, 100);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h10);
    wr(smbus_slice_pkg::SLT_HI_ADDR, 8'h0A);
    wr(smbus_slice_pkg::SLT_LO_ADDR, 8'h00);
    partner.lines(1'b1, 1'b1, 20);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h14);
    partner.lines(1'b1, 1'b0, 3);
    partner.lines(1'b0, 1'b1, 2);
    // Two short runs that only trip the flag if the count carried over
    partner.lines(1'b1, 1'b0, 4);
    partner.lines(1'b0, 1'b1, 2);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h10);
    partner.lines(1'b1, 1'b0, 20);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h12);
    rd(smbus_slice_pkg::STATE_ADDR, {5'h0, lastm, 2'b00});
    wr(smbus_slice_pkg::SMB_ADDR, 8'h11);
    rd(smbus_slice_pkg::STATE_ADDR, {5'h0, lastm, 2'b10});
    partner.lines(1'b0, 1'b1, 2);
    wr(smbus_slice_pkg::SMB_ADDR, 8'h13);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h11);
    partner.lines(1'b0, 1'b1, 2600);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h19);
    partner.lines(1'b1, 1'b1, 1);
    rd(smbus_slice_pkg::STATE_ADDR, {5'h0, lastm, 2'b01});
    partner.lines(1'b1, 1'b1, 20);
    wr(smbus_slice_pkg::SMB_ADDR, 8'h19);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h15);
    // Divided timeout clock: 16 ticks of 64 cycles
    wr(smbus_slice_pkg::SLT_HI_ADDR, 8'h00);
    wr(smbus_slice_pkg::SLT_LO_ADDR, 8'h10);
    wr(smbus_slice_pkg::SMB_ADDR, 8'h08);
    partner.lines(1'b0, 1'b1, 512);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h00);
    partner.lines(1'b0, 1'b1, 600);
    rd(smbus_slice_pkg::SMB_ADDR, 8'h08);
    partner.lines(1'b1, 1'b1, 2);
    report_and_stop();
  end
endmodule
